// ### tws_config_slave.sv
`timescale 1ns/10ps
// Overview of operation
// [R1] the serial engine is a slave only and never starts a transfer
// [R2] frames are sixteen bits per select-low period; other writes dropped
// [R3] msb first: D15-D10 address, D7-D0 data byte
// [R4] D9 chooses direction: 0 write, 1 read
// [R5] D8 is a turnaround slot, ignored on writes and reads
// [R6] on reads the device drives eight data bits, sampled on rising clock
// [R7] on reads the controller floats the data line from D8 onward
// [R8] writes apply at next vsync fall; reset and standby apply at once
// [R9] reg 0 bit 0: 0 sync mode, 1 data-enable mode (default)
// [R10] reg 0 bit 1: pixel clock edge, 0 falling (default), 1 rising
// [R11] reg 0 bit 2: soft reset, 0 holds reset, 1 runs (default)
// [R12] reg 0 bit 3: 0 standby with outputs off, 1 normal (default)
// [R13] reg 0 bit 4: scan direction picks start output and direction level
// [R14] reg 0 bit 5: source shift, 1 right (default), 0 left
// [R15] reg 0 bit 7: power block enable, default off
// [R16] reg 1 bits 2:1 resolution; 800-wide modes disable channels 601-936
// [R17] reg 1 bit 3 runs internal test pattern without pixel clock
// [R18] reg 1 bit 4 dithering, bit 5 h-frc; bit 4 low disables both
// [R19] reg 1 bits 7:6 adaptive backlight mode, default off
// [R20] reg 2 bit 6 panel type; standby level 3Fh white, 00h black
// [R21] reg 2 bit 7 inversion pattern, default one-plus-two dot
// [R22] reg 3 bits 1:0 gate-on sequence, bit 2 uniform frame polarity
// [R23] strap high: pin levels replace register controls except soft reset, standby and inversion pattern
// [R24] controller holds select low through a frame, high between frames
// [R25] reserved bits and unmapped addresses read zero, writes ignored
module tws_config_slave
	import tws_pkg::*;
(
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        arst_n,
	// three-wire serial link
	input  wire logic        serial_select_n,
	input  wire logic        serial_clock,
	input  wire logic        serial_data_in,
	output logic             serial_data_out,
	output logic             serial_data_oe,
	// frame sync and strap
	input  wire logic        vertical_sync_in,
	input  wire logic        strap_control_enable,
	// strap pin levels
	input  wire logic        pin_timing_mode,
	input  wire logic        pin_clock_edge,
	input  wire logic        pin_gate_scan,
	input  wire logic        pin_source_shift,
	input  wire logic        pin_power_enable,
	input  wire logic [1:0]  pin_resolution,
	input  wire logic        pin_test_pattern,
	input  wire logic        pin_dithering,
	input  wire logic        pin_horizontal_frc,
	input  wire logic [1:0]  pin_backlight_mode,
	input  wire logic        pin_panel_type,
	input  wire logic        pin_frame_uniform,
	input  wire logic [1:0]  pin_gate_sequence,
	// applied controls
	output logic             timing_de_mode,
	output logic             pixel_clock_edge_sel,
	output logic             global_soft_reset_n,
	output logic             standby_n,
	output logic             gate_scan_direction,
	output logic             gate_direction_out,
	output logic             vertical_start_a_sel,
	output logic             vertical_start_b_sel,
	output logic             source_shift_direction,
	output logic             power_block_enable,
	output logic [1:0]       resolution_select,
	output logic             upper_channels_off,
	output logic             test_pattern_enable,
	output logic             dithering_enable,
	output logic             horizontal_frc_enable,
	output logic [1:0]       adaptive_backlight_mode,
	output logic             panel_black_white_type,
	output logic [5:0]       standby_low_level,
	output logic             inversion_pattern_select,
	output logic [1:0]       gate_on_sequence,
	output logic             frame_uniform
);

	// ----------------------------------------------------------------
	// reset release
	// ----------------------------------------------------------------
	logic       rst_s1;
	logic       rst_n;
	tws_state_t st;
	tws_state_t n;
	logic [IN_W-1:0] in_raw;
	logic [IN_W-1:0] agree;
	logic       sclk_rise;
	logic       sclk_fall;
	logic       csn_rise;
	logic       vs_fall;
	logic       in_frame;
	logic       strap;
	logic [3:0][7:0] pin_img;
	logic [3:0][7:0] pin_msk;
	logic [3:0][7:0] wr_msk;

	// two-flop release of the asynchronous reset
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_s1 <= 1'b0;
			rst_n  <= 1'b0;
		end else begin
			rst_s1 <= 1'b1;
			rst_n  <= rst_s1;
		end
	end

	// ----------------------------------------------------------------
	// input gathering and constant maps
	// ----------------------------------------------------------------

	// all outside inputs in one vector for the three-stage filter
	assign in_raw = {pin_gate_sequence, pin_frame_uniform, pin_panel_type,
		pin_backlight_mode, pin_horizontal_frc, pin_dithering,
		pin_test_pattern, pin_resolution, pin_power_enable,
		pin_source_shift, pin_gate_scan, pin_clock_edge,
		pin_timing_mode, strap_control_enable, vertical_sync_in,
		serial_select_n, serial_data_in, serial_clock};

	assign wr_msk  = {MSK_D, MSK_C, MSK_B, MSK_A};
	assign pin_msk = {PIN_D, PIN_C, PIN_B, PIN_A};

	// strap pin levels laid out like the register images
	assign pin_img[0] = {st.f[IN_PIN+4], 1'b0, st.f[IN_PIN+3],
		st.f[IN_PIN+2], 2'b00, st.f[IN_PIN+1], st.f[IN_PIN]};
	assign pin_img[1] = {st.f[IN_PIN+11:IN_PIN+10], st.f[IN_PIN+9],
		st.f[IN_PIN+8], st.f[IN_PIN+7], st.f[IN_PIN+6:IN_PIN+5], 1'b0};
	assign pin_img[2] = {1'b0, st.f[IN_PIN+12], 6'h00};
	assign pin_img[3] = {5'h00, st.f[IN_PIN+13], st.f[IN_PIN+15:IN_PIN+14]};

	// ----------------------------------------------------------------
	// next-state logic
	// ----------------------------------------------------------------
	always_comb begin
		n = st;

		// first stage is read only by the second stage
		n.s1  = in_raw;
		n.s2  = st.s1;
		n.s3  = st.s2;
		agree = ~(st.s2 ^ st.s3);
		n.f   = (agree & st.s3) | (~agree & st.f);

		sclk_rise = n.f[IN_SCLK] & ~st.f[IN_SCLK];
		sclk_fall = ~n.f[IN_SCLK] & st.f[IN_SCLK];
		csn_rise  = n.f[IN_CSN] & ~st.f[IN_CSN];
		vs_fall   = ~n.f[IN_VS] & st.f[IN_VS];
		in_frame  = ~st.f[IN_CSN];
		strap     = st.f[IN_STRAP];

		// [R1] slave engine
		// reacts only to the controller's edges, idles when deselected
		if (!in_frame) begin
			n.cnt = 5'h00;
			n.rd  = 1'b0;
			n.oe  = 1'b0;
		end else if (sclk_rise) begin
			// [R3] msb first capture
			n.shift = {st.shift[6:0], n.f[IN_SDA]};
			n.cnt   = (st.cnt == CNT_MAX) ? st.cnt : st.cnt + 5'h01;
			if (st.cnt == CNT_ADDR_LO)
				n.addr = {st.shift[4:0], n.f[IN_SDA]};
			// [R4] direction bit
			if (st.cnt == CNT_DIR)
				n.rd = n.f[IN_SDA];
			// [R25] unmapped addresses return zero
			if (st.cnt == CNT_TURN)
				n.rbyte = (st.addr[5:2] == 4'h0) ?
					st.shadow[st.addr[1:0]] : 8'h00;
		end else if (sclk_fall) begin
			// [R6] drive data on falling edge for rising capture
			if (st.rd && st.cnt >= CNT_DATA && st.cnt < CNT_FRAME) begin
				n.oe   = 1'b1;
				n.dout = st.rbyte[~st.cnt[2:0]];
			end else begin
				n.oe   = 1'b0;
			end
		end

		// [R2] commit only an exact sixteen-bit write
		// [R5] turnaround bit is never used on writes
		if (csn_rise && st.cnt == CNT_FRAME && !st.rd &&
			st.addr[5:2] == 4'h0)
			n.shadow[st.addr[1:0]] = st.shift & wr_msk[st.addr[1:0]];

		// [R8] staged values move on at the vsync falling edge
		if (vs_fall)
			n.active = n.shadow;

		// [R23] strap hands pin-owned fields to the pins
		for (int i = 0; i < REG_NUM; i++)
			n.eff[i] = strap ?
				((n.active[i] & ~pin_msk[i]) | (pin_img[i] & pin_msk[i])) :
				n.active[i];

		// [R8] reset and standby bypass the vsync staging
		n.eff[0][A_GRB]  = n.shadow[0][A_GRB];
		n.eff[0][A_STBY] = n.shadow[0][A_STBY];
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			st        <= '0;
			st.s1     <= IN_RST;
			st.s2     <= IN_RST;
			st.s3     <= IN_RST;
			st.f      <= IN_RST;
			st.shadow <= {RST_D, RST_C, RST_B, RST_A};
			st.active <= {RST_D, RST_C, RST_B, RST_A};
			st.eff    <= {RST_D, RST_C, RST_B, RST_A};
		end else begin
			st <= n;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------

	// serial data line
	assign serial_data_out = st.dout;
	assign serial_data_oe  = st.oe;

	// [R9] timing mode
	assign timing_de_mode         = st.eff[0][A_MODE];
	// [R10] sampling edge
	assign pixel_clock_edge_sel   = st.eff[0][A_EDGE];
	// [R11] soft reset
	assign global_soft_reset_n    = st.eff[0][A_GRB];
	// [R12] standby control
	assign standby_n              = st.eff[0][A_STBY];
	// [R13] start output choice
	assign gate_scan_direction    = st.eff[0][A_GATE_SCAN_DIRECTION];
	assign gate_direction_out     = st.eff[0][A_GATE_SCAN_DIRECTION];
	assign vertical_start_a_sel   = st.eff[0][A_GATE_SCAN_DIRECTION];
	assign vertical_start_b_sel   = ~st.eff[0][A_GATE_SCAN_DIRECTION];
	// [R14] source shift
	assign source_shift_direction = st.eff[0][A_SHIFT];
	// [R15] power blocks
	assign power_block_enable     = st.eff[0][A_PWR];
	// [R16] resolution and narrow modes
	assign resolution_select      = st.eff[1][B_RES+1:B_RES];
	assign upper_channels_off     = st.eff[1][B_RES+1];
	// [R17] test pattern
	assign test_pattern_enable    = st.eff[1][B_TEST];
	// [R18] dithering gate
	assign dithering_enable       = st.eff[1][B_DITH];
	assign horizontal_frc_enable  = st.eff[1][B_DITH] & st.eff[1][B_HORIZONTAL_FRC_ENABLE];
	// [R19] backlight mode
	assign adaptive_backlight_mode = st.eff[1][B_CABC+1:B_CABC];
	// [R20] panel type and standby level
	assign panel_black_white_type = st.eff[2][C_NBW];
	assign standby_low_level      = st.eff[2][C_NBW] ? LVL_BLACK : LVL_WHITE;
	// [R21] inversion pattern
	assign inversion_pattern_select = st.eff[2][C_INV];
	// [R22] gate sequence and frame polarity
	assign gate_on_sequence       = st.eff[3][D_SEL+1:D_SEL];
	assign frame_uniform          = st.eff[3][D_FRAME];

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	sequence wr_commit_s;
		csn_rise && st.cnt == CNT_FRAME && !st.rd && st.addr == 6'h00;
	endsequence

	sequence bad_len_s;
		csn_rise && st.cnt != CNT_FRAME;
	endsequence

	slave_drive_a: assert property ( // [R1]
		st.oe |-> !st.f[IN_CSN] && st.rd)
		else $error("data line driven outside a read frame");

	bad_length_a: assert property ( // [R2]
		bad_len_s |=> $stable(st.shadow))
		else $error("register changed by a frame of wrong length");

	data_phase_a: assert property ( // [R5]
		$rose(st.oe) |-> st.cnt == CNT_DATA)
		else $error("read data driven before the data phase");

	read_order_a: assert property ( // [R6]
		st.oe && $changed(st.cnt) |-> ##[1:80] sclk_fall || !in_frame)
		else $error("read bit not followed by a falling edge");

	staged_apply_a: assert property ( // [R8]
		!vs_fall |=> $stable(st.active))
		else $error("active value changed without vsync fall");

	standby_now_a: assert property ( // [R8]
		wr_commit_s |=> standby_n == $past(st.shift[A_STBY]))
		else $error("standby did not follow the write at once");

	dithering_enable_gate_a: assert property ( // [R18]
		horizontal_frc_enable |-> dithering_enable)
		else $error("h-frc active while dithering is off");

	scan_pair_a: assert property ( // [R13]
		vertical_start_a_sel != vertical_start_b_sel &&
		gate_direction_out == vertical_start_a_sel)
		else $error("start output choice inconsistent");

	strap_pins_a: assert property ( // [R23]
		strap ##1 strap |-> test_pattern_enable == $past(st.f[IN_PIN+7]))
		else $error("strap high but register steers test pattern");

	reserved_zero_a: assert property ( // [R25]
		(st.shadow[0] & ~MSK_A) == 8'h00 && (st.shadow[2] & ~MSK_C) == 8'h00)
		else $error("reserved register bits set");

	sequence turn_unmapped_s;
		sclk_rise && in_frame && st.cnt == CNT_TURN &&
		st.addr[5:2] != 4'h0;
	endsequence

	line_release_a: assert property ( // [R1]
		!in_frame |=> !st.oe)
		else $error("data line still driven after deselect");

	first_bit_a: assert property ( // [R6]
		$rose(st.oe) |-> st.dout == st.rbyte[7])
		else $error("first read bit is not the data msb");

	unmapped_read_a: assert property ( // [R25]
		turn_unmapped_s |=> st.rbyte == 8'h00)
		else $error("unmapped address returned nonzero data");

	vsync_apply_a: assert property ( // [R8]
		vs_fall |=> st.active == $past(n.shadow))
		else $error("staged values not applied at vsync fall");

	reset_now_a: assert property ( // [R11]
		wr_commit_s |=> global_soft_reset_n == $past(st.shift[A_GRB]))
		else $error("soft reset did not follow the write at once");

	reserved_more_a: assert property ( // [R25]
		(st.shadow[1] & ~MSK_B) == 8'h00 &&
		(st.shadow[3] & ~MSK_D) == 8'h00)
		else $error("reserved bits set in registers 1 or 3");

endmodule

// ### tws_pkg.sv
package tws_pkg;

	// ----------------------------------------------------------------
	// serial frame layout
	// ----------------------------------------------------------------
	localparam int         FRAME_BITS  = 16;
	localparam logic [4:0] CNT_ADDR_LO = 5'h05; // bits taken before D10
	localparam logic [4:0] CNT_DIR     = 5'h06; // bits taken before D9
	localparam logic [4:0] CNT_TURN    = 5'h07; // bits taken before D8
	localparam logic [4:0] CNT_DATA    = 5'h08; // first data bit D7 next
	localparam logic [4:0] CNT_FRAME   = 5'h10; // exactly sixteen bits
	localparam logic [4:0] CNT_MAX     = 5'h11; // saturates above frame
	localparam int         ADDR_W      = 6;
	localparam int         REG_NUM     = 4;

	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [5:0] SYSTEM_CONTROL_A_OFS      = 6'h00;
	localparam logic [5:0] SYSTEM_CONTROL_B_OFS      = 6'h01;
	localparam logic [5:0] SYSTEM_CONTROL_C_OFS      = 6'h02;
	localparam logic [5:0] GATE_SEQUENCE_CONTROL_OFS = 6'h03;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int A_MODE   = 0;
	localparam int A_EDGE   = 1;
	localparam int A_GRB    = 2;
	localparam int A_STBY   = 3;
	localparam int A_GATE_SCAN_DIRECTION   = 4;
	localparam int A_SHIFT  = 5;
	localparam int A_PWR    = 7;
	localparam int B_RES    = 1;
	localparam int B_TEST   = 3;
	localparam int B_DITH   = 4;
	localparam int B_HORIZONTAL_FRC_ENABLE   = 5;
	localparam int B_CABC   = 6;
	localparam int C_NBW    = 6;
	localparam int C_INV    = 7;
	localparam int D_SEL    = 0;
	localparam int D_FRAME  = 2;

	// ----------------------------------------------------------------
	// reset values, writable masks, strap-owned masks
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_A = 8'h2D;
	localparam logic [7:0] RST_B = 8'h00;
	localparam logic [7:0] RST_C = 8'h00;
	localparam logic [7:0] RST_D = 8'h00;
	localparam logic [7:0] MSK_A = 8'hBF;
	localparam logic [7:0] MSK_B = 8'hFE;
	localparam logic [7:0] MSK_C = 8'hC0;
	localparam logic [7:0] MSK_D = 8'h07;
	localparam logic [7:0] PIN_A = 8'hB3;
	localparam logic [7:0] PIN_B = 8'hFE;
	localparam logic [7:0] PIN_C = 8'h40;
	localparam logic [7:0] PIN_D = 8'h07;

	// standby low level per panel type
	localparam logic [5:0] LVL_WHITE = 6'h3F;
	localparam logic [5:0] LVL_BLACK = 6'h00;

	// ----------------------------------------------------------------
	// asynchronous input vector
	// ----------------------------------------------------------------
	localparam int         IN_SCLK  = 0;
	localparam int         IN_SDA   = 1;
	localparam int         IN_CSN   = 2;
	localparam int         IN_VS    = 3;
	localparam int         IN_STRAP = 4;
	localparam int         IN_PIN   = 5;
	localparam int         PIN_W    = 16;
	localparam int         IN_W     = 21;
	localparam logic [20:0] IN_RST  = 21'h00_000C; // select, vsync idle high

	typedef struct packed {
		logic [IN_W-1:0]       s1;
		logic [IN_W-1:0]       s2;
		logic [IN_W-1:0]       s3;
		logic [IN_W-1:0]       f;
		logic [4:0]            cnt;
		logic [7:0]            shift;
		logic [ADDR_W-1:0]     addr;
		logic                  rd;
		logic [7:0]            rbyte;
		logic                  oe;
		logic                  dout;
		logic [3:0][7:0]       shadow;
		logic [3:0][7:0]       active;
		logic [3:0][7:0]       eff;
	} tws_state_t;

endpackage

// ### tws_host_model.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// serial master on the far side of the link
// ----------------------------------------------------------------
module tws_host_model (
	// wire level seen at the data pin
	input  wire logic line,
	// link outputs
	output logic      serial_select_n,
	output logic      serial_clock,
	output logic      host_data,
	output logic      host_oe
);
	// half of the 125 ns link period, unrelated to sys_clk
	localparam realtime HALF = 62.5;

	// idle: deselected, clock parked low, line released
	initial begin
		serial_select_n = 1'b1;
		serial_clock = 1'b0;
		host_data = 1'b0;
		host_oe = 1'b0;
	end

	// one transfer, msb first; data changes while the clock is low
	task automatic xfer(input logic [15:0] word, input int nbits,
			output logic [7:0] rdata);
		rdata = 8'h00;
		serial_select_n <= 1'b0;
		#HALF;
		for (int i = 0; i < nbits; i++) begin
			// float line from turnaround on reads
			host_oe <= !(word[9] && i >= 7);
			host_data <= word[15 - (i % 16)];
			#HALF;
			serial_clock <= 1'b1;
			// take data bits on rise only
			if (i >= 8)
				rdata = {rdata[6:0], line};
			#HALF;
			serial_clock <= 1'b0;
		end
		#HALF;
		serial_select_n <= 1'b1;
		host_oe <= 1'b0;
		#(2 * HALF);
	endtask
endmodule

// ### testbench.sv
`timescale 1ns/10ps
module testbench;
	import tws_pkg::*;
	// clock, reset, sync, strap and pin levels
	logic sys_clk, arst_n, vertical_sync_in = 1'b1;
	logic strap_control_enable = 1'b0, pin_timing_mode = 1'b0;
	logic pin_clock_edge = 1'b0, pin_gate_scan = 1'b0;
	logic pin_source_shift = 1'b0, pin_power_enable = 1'b0;
	logic pin_test_pattern = 1'b0, pin_dithering = 1'b0;
	logic pin_horizontal_frc = 1'b0, pin_panel_type = 1'b0;
	logic pin_frame_uniform = 1'b0;
	logic [1:0] pin_resolution = 2'h0, pin_backlight_mode = 2'h0;
	logic [1:0] pin_gate_sequence = 2'h0;
	// link wires
	logic serial_select_n, serial_clock, serial_data_in;
	logic serial_data_out, serial_data_oe, host_data, host_oe;
	// applied controls
	logic timing_de_mode, pixel_clock_edge_sel, global_soft_reset_n;
	logic standby_n, gate_scan_direction, gate_direction_out;
	logic vertical_start_a_sel, vertical_start_b_sel;
	logic source_shift_direction, power_block_enable;
	logic upper_channels_off, test_pattern_enable, dithering_enable;
	logic horizontal_frc_enable, panel_black_white_type;
	logic inversion_pattern_select, frame_uniform, clash = 1'b0;
	logic [1:0] resolution_select, adaptive_backlight_mode;
	logic [1:0] gate_on_sequence;
	logic [5:0] standby_low_level;
	int failures = 0, checked = 0;

	tws_config_slave dut (.*);
	tws_host_model host (
		.line            (serial_data_in),
		.serial_select_n (serial_select_n),
		.serial_clock    (serial_clock),
		.host_data       (host_data),
		.host_oe         (host_oe)
	);

	// wire level: device, then host, else the pull-down
	assign serial_data_in = serial_data_oe ? serial_data_out :
		(host_oe ? host_data : 1'b0);

	// flags any cycle where both parties drive the line
	always @(posedge sys_clk)
		if (serial_data_oe === 1'b1 && host_oe)
			clash <= 1'b1;

	// clock generator
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic finish_test();
		$display("checks=%0d failures=%0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// raw frame of any length, then settle
	task automatic send(input logic [15:0] w, input int n);
		logic [7:0] r;
		host.xfer(w, n, r);
		repeat (6) @(posedge sys_clk);
	endtask

	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		send({a, 2'b00, d}, 16);
	endtask

	task automatic rdchk(input logic [5:0] a, input logic [7:0] exp);
		logic [7:0] r;
		host.xfer({a, 2'b10, 8'h00}, 16, r);
		repeat (6) @(posedge sys_clk);
		chk(r, exp);
	endtask

	// one low pulse on frame sync
	task automatic vsync();
		@(posedge sys_clk) vertical_sync_in <= 1'b0;
		repeat (8) @(posedge sys_clk);
		vertical_sync_in <= 1'b1;
		repeat (8) @(posedge sys_clk);
	endtask

	task automatic t_defaults();
		chk(timing_de_mode, 1'b1);
		chk(pixel_clock_edge_sel, 1'b0);
		chk(global_soft_reset_n, 1'b1);
		chk(standby_n, 1'b1);
		chk({gate_scan_direction, gate_direction_out, vertical_start_a_sel,
			vertical_start_b_sel}, 4'h1);
		chk(source_shift_direction, 1'b1);
		chk(power_block_enable, 1'b0);
		chk(standby_low_level, 6'h3F);
		rdchk(6'h00, 8'h2D);
		$display("t_defaults done");
	endtask

	task automatic t_staging();
		wr(6'h00, 8'hD2);
		chk({global_soft_reset_n, standby_n}, 2'h0);
		chk({power_block_enable, timing_de_mode}, 2'h1);
		vsync();
		chk(power_block_enable, 1'b1);
		chk({gate_scan_direction, gate_direction_out, vertical_start_a_sel,
			vertical_start_b_sel}, 4'hE);
		chk(pixel_clock_edge_sel, 1'b1);
		chk(source_shift_direction, 1'b0);
		chk(timing_de_mode, 1'b0);
		rdchk(6'h00, 8'h92);
		wr(6'h00, 8'h2D);
		vsync();
		$display("t_staging done");
	endtask

	// every resolution, backlight, sequence and panel code
	task automatic t_codes();
		logic [1:0] k;
		logic [7:0] v;
		for (int i = 0; i < 4; i++) begin
			k = i[1:0];
			v = {k, k[0], 1'b1, k[1], k, 1'b0};
			wr(6'h01, v);
			wr(6'h02, {k, 6'h00});
			wr(6'h03, {5'h00, k[0], k});
			vsync();
			chk({resolution_select, upper_channels_off}, {k, k[1]});
			chk(adaptive_backlight_mode, k);
			chk(test_pattern_enable, k[1]);
			chk({dithering_enable, horizontal_frc_enable}, {1'b1, k[0]});
			chk({gate_on_sequence, frame_uniform}, {k, k[0]});
			chk(standby_low_level, k[0] ? 6'h00 : 6'h3F);
			chk(inversion_pattern_select, k[1]);
			chk(panel_black_white_type, k[0]);
			rdchk(6'h01, v);
		end
		wr(6'h01, 8'h20);
		vsync();
		chk({dithering_enable, horizontal_frc_enable}, 2'h0);
		$display("t_codes done");
	endtask

	task automatic t_refused();
		wr(6'h01, 8'hFF);
		rdchk(6'h01, 8'hFE);
		wr(6'h02, 8'hFF);
		rdchk(6'h02, 8'hC0);
		send({6'h02, 2'b00, 8'h00}, 15);
		send({6'h02, 2'b00, 8'h00}, 17);
		rdchk(6'h02, 8'hC0);
		send({6'h03, 2'b01, 8'hFD}, 16);
		rdchk(6'h03, 8'h05);
		wr(6'h05, 8'hAA);
		rdchk(6'h05, 8'h00);
		$display("t_refused done");
	endtask

	task automatic t_strap();
		@(posedge sys_clk);
		pin_resolution <= 2'h2;
		pin_power_enable <= 1'b1;
		pin_gate_sequence <= 2'h1;
		strap_control_enable <= 1'b1;
		repeat (12) @(posedge sys_clk);
		chk({resolution_select, power_block_enable}, 3'h5);
		chk(gate_on_sequence, 2'h1);
		chk({panel_black_white_type, inversion_pattern_select}, 2'h1);
		strap_control_enable <= 1'b0;
		repeat (12) @(posedge sys_clk);
		chk(power_block_enable, 1'b0);
		chk({gate_on_sequence, panel_black_white_type}, 3'h7);
		$display("t_strap done");
	endtask

	// run-away guard
	initial begin
		#400000;
		failures++;
		finish_test();
	end

	// main sequence
	initial begin
		arst_n = 1'b0;
		repeat (3) @(posedge sys_clk);
		arst_n <= 1'b1;
		repeat (8) @(posedge sys_clk);
		t_defaults();
		t_staging();
		t_codes();
		t_refused();
		t_strap();
		chk(clash, 1'b0);
		finish_test();
	end
endmodule
